/* File: include/etol_pkg.sv */
package etol_pkg;

	// outbound frame geometry
	localparam int          E3_FRAME_BITS = 1536;
	localparam int          OVH_BITS      = 12;
	localparam int          FAS_BITS      = 10;
	localparam int          OVH_A_IDX     = 10;
	localparam int          OVH_N_IDX     = 11;
	localparam int          STROBE_LEAD   = 3;
	localparam logic        A_BIT_DEFAULT = 1'b0;
	localparam logic        N_BIT_IDLE    = 1'b1;
	localparam logic [1:0]  NSRC_MSG      = 2'h2;

	// message frame octets
	localparam logic [7:0]  FLAG_OCTET    = 8'h7E;
	localparam logic [7:0]  ADDR1_CMD     = 8'h3C;
	localparam logic [7:0]  ADDR1_RSP     = 8'h3E;
	localparam logic [7:0]  ADDR2_OCTET   = 8'h01;
	localparam logic [7:0]  CTRL_OCTET    = 8'h03;
	localparam logic [15:0] CRC_INIT      = 16'hFFFF;
	localparam logic [15:0] CRC_POLY_REFL = 16'h8408;
	localparam logic [2:0]  STUFF_RUN     = 3'h5;

	// transmit message buffer
	localparam int          BUF_DEPTH     = 88;
	localparam logic [7:0]  BUF_BASE      = 8'h86;
	localparam logic [7:0]  BUF_LAST      = 8'hDD;
	localparam logic [6:0]  LEN_SHORT     = 7'h4C;
	localparam logic [6:0]  LEN_LONG      = 7'h52;

endpackage

/* File: design/etol_msg_buffer.sv */
module etol_msg_buffer #(
	parameter int DEPTH = 88,
	parameter int AW    = 7
)(
	input  wire logic          sys_clk,
	input  wire logic          ce,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [7:0]    wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [7:0]    rd_data
);

	logic [7:0] mem [DEPTH];

	// no reset on storage; software fills it before a send
	always_ff @(posedge sys_clk) begin
		if (ce) begin
			if (wr_en) begin
				mem[wr_addr] <= wr_data;
			end
			rd_data <= mem[rd_addr];
		end
	end

endmodule

/* File: design/etol_tx_overhead_lapd.sv */
module etol_tx_overhead_lapd
	import etol_pkg::*;
#(
	parameter int         FRAME_BITS  = E3_FRAME_BITS,
	parameter logic [9:0] FAS_PATTERN = 10'h3D0
)(
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire logic       ce,
	input  wire logic       payload_bit_in,
	output logic            payload_bit_take,
	output logic            tx_bit_out,
	output logic            ovh_frame_boundary_out,
	output logic            ovh_bit_strobe_out,
	input  wire logic       ovh_insert_request_in,
	input  wire logic       ovh_insert_value_in,
	input  wire logic [1:0] n_bit_source_select,
	input  wire logic       message_tx_enable,
	input  wire logic       message_size_select,
	input  wire logic       message_cr_select,
	input  wire logic       message_send_in,
	input  wire logic       buf_wr_en,
	input  wire logic [7:0] buf_wr_addr,
	input  wire logic [7:0] buf_wr_data,
	output logic            message_busy_out,
	output logic            message_sent_out
);

	localparam int PW = $clog2(FRAME_BITS);
	// first strobe run after reset is whole and opens with the boundary
	localparam logic [PW-1:0] POS_AT_RESET = PW'(FRAME_BITS - STROBE_LEAD - 1);

	typedef enum logic [3:0] {
		MS_IDLE, MS_OPEN, MS_ADDR1, MS_ADDR2, MS_CTRL,
		MS_PAYLOAD, MS_FCS_HI, MS_FCS_LO, MS_CLOSE
	} etol_msg_state_t;

	function automatic logic [PW-1:0] wrap_add(input logic [PW-1:0] p, input int k);
		int s;
		s = int'(p) + k;
		if (s >= FRAME_BITS) begin
			s = s - FRAME_BITS;
		end
		return PW'(s);
	endfunction

	// reflected form so the check runs least significant bit first, like the data
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
		logic fb;
		fb = c[0] ^ b;
		return fb ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
	endfunction

	// frame timing and overhead port
	logic [PW-1:0] pos;
	logic [PW-1:0] next_pos;
	logic [PW-1:0] ahead;
	logic          next_strobe;
	logic          next_boundary;
	logic          ins_meta;
	logic          ins_sync;
	logic          val_meta;
	logic          val_sync;
	logic          next_tx_bit;
	logic          in_ovh;
	logic [3:0]    fas_idx;
	logic          n_bit;
	logic          msg_active;

	// message framer
	etol_msg_state_t mstate;
	etol_msg_state_t next_mstate;
	logic [7:0]      sh;
	logic [7:0]      next_sh;
	logic [2:0]      bitn;
	logic [2:0]      next_bitn;
	logic [2:0]      ones;
	logic [2:0]      next_ones;
	logic [15:0]     crc;
	logic [15:0]     next_crc;
	logic [15:0]     frame_check_sequence;
	logic [7:0]      fcs_lo;
	logic [7:0]      next_fcs_lo;
	logic [6:0]      idx;
	logic [6:0]      next_idx;
	logic            pending;
	logic            next_pending;
	logic            next_sent;
	logic            tick;
	logic            stuff_due;
	logic            in_body;
	logic            in_crc;
	logic            hdlc_bit;
	logic [6:0]      msg_len;
	logic [7:0]      rd_data;
	logic            buf_hit;
	logic [7:0]      buf_off;

	always_comb begin
		next_pos      = wrap_add(pos, 1);
		ahead         = wrap_add(next_pos, STROBE_LEAD);
		// strobe leads the bit by the terminal's register plus our two-flop sampler
		next_strobe   = (ahead < PW'(OVH_BITS));
		next_boundary = (ahead == '0);
	end

	always_comb begin
		in_ovh     = (pos < PW'(OVH_BITS));
		fas_idx    = 4'(FAS_BITS - 1) - pos[3:0];
		msg_active = message_tx_enable && (n_bit_source_select == NSRC_MSG);
		n_bit      = msg_active ? hdlc_bit : N_BIT_IDLE;
		payload_bit_take = ce && !in_ovh;
		if (!in_ovh) begin
			next_tx_bit = payload_bit_in;
		end else if (ins_sync) begin
			next_tx_bit = val_sync;
		end else if (pos < PW'(FAS_BITS)) begin
			next_tx_bit = FAS_PATTERN[fas_idx];
		end else if (pos == PW'(OVH_A_IDX)) begin
			next_tx_bit = A_BIT_DEFAULT;
		end else begin
			next_tx_bit = n_bit;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pos                    <= POS_AT_RESET;
			ovh_bit_strobe_out     <= 1'b0;
			ovh_frame_boundary_out <= 1'b0;
			ins_meta               <= 1'b0;
			ins_sync               <= 1'b0;
			val_meta               <= 1'b0;
			val_sync               <= 1'b0;
			tx_bit_out             <= 1'b1;
		end else if (ce) begin
			pos                    <= next_pos;
			ovh_bit_strobe_out     <= next_strobe;
			ovh_frame_boundary_out <= next_boundary;
			ins_meta               <= ovh_insert_request_in;
			ins_sync               <= ins_meta;
			val_meta               <= ovh_insert_value_in;
			val_sync               <= val_meta;
			tx_bit_out             <= next_tx_bit;
		end
	end

	// one message bit per outbound frame, consumed at the N position
	always_comb begin
		tick      = (pos == PW'(OVH_N_IDX));
		stuff_due = (ones == STUFF_RUN);
		hdlc_bit  = stuff_due ? 1'b0 : sh[0];
		in_body   = (mstate inside {MS_ADDR1, MS_ADDR2, MS_CTRL, MS_PAYLOAD,
			MS_FCS_HI, MS_FCS_LO});
		in_crc    = (mstate inside {MS_ADDR1, MS_ADDR2, MS_CTRL, MS_PAYLOAD});
		msg_len   = message_size_select ? LEN_LONG : LEN_SHORT;
		message_busy_out = pending || (mstate != MS_IDLE);
	end

	always_comb begin
		next_mstate  = mstate;
		next_sh      = sh;
		next_bitn    = bitn;
		next_ones    = ones;
		next_crc     = crc;
		next_fcs_lo  = fcs_lo;
		next_idx     = idx;
		next_pending = pending;
		next_sent    = 1'b0;
		frame_check_sequence          = ~crc;
		if (!msg_active) begin
			next_mstate  = MS_IDLE;
			next_sh      = FLAG_OCTET;
			next_bitn    = '0;
			next_ones    = '0;
			next_idx     = '0;
			next_pending = 1'b0;
		end else if (tick) begin
			if (stuff_due) begin
				next_ones = '0;
			end else begin
				next_ones = (in_body && sh[0]) ? ones + 3'h1 : 3'h0;
				if (in_crc) begin
					next_crc = crc_step(crc, sh[0]);
				end
				frame_check_sequence       = ~next_crc;
				next_sh   = {1'b0, sh[7:1]};
				next_bitn = bitn + 3'h1;
				if (bitn == 3'h7) begin
					case (mstate)
						MS_IDLE, MS_CLOSE: begin
							next_sent   = (mstate == MS_CLOSE);
							next_sh     = FLAG_OCTET;
							next_mstate = pending ? MS_OPEN : MS_IDLE;
							if (pending) begin
								next_pending = 1'b0;
							end
						end
						MS_OPEN: begin
							next_mstate = MS_ADDR1;
							next_sh     = message_cr_select ? ADDR1_RSP : ADDR1_CMD;
							next_crc    = CRC_INIT;
							next_idx    = '0;
						end
						MS_ADDR1: begin
							next_mstate = MS_ADDR2;
							next_sh     = ADDR2_OCTET;
						end
						MS_ADDR2: begin
							next_mstate = MS_CTRL;
							next_sh     = CTRL_OCTET;
						end
						MS_CTRL: begin
							next_mstate = MS_PAYLOAD;
							next_sh     = rd_data;
							next_idx    = 7'h1;
						end
						MS_PAYLOAD: begin
							if (idx == msg_len) begin
								next_mstate = MS_FCS_HI;
								next_sh     = frame_check_sequence[15:8];
								next_fcs_lo = frame_check_sequence[7:0];
							end else begin
								next_sh  = rd_data;
								next_idx = idx + 7'h1;
							end
						end
						MS_FCS_HI: begin
							next_mstate = MS_FCS_LO;
							next_sh     = fcs_lo;
						end
						MS_FCS_LO: begin
							next_mstate = MS_CLOSE;
							next_sh     = FLAG_OCTET;
						end
						default: begin
							next_mstate = MS_IDLE;
							next_sh     = FLAG_OCTET;
						end
					endcase
				end
			end
		end
		// a send request in the clearing cycle is kept
		if (message_send_in) begin
			next_pending = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			mstate           <= MS_IDLE;
			sh               <= FLAG_OCTET;
			bitn             <= '0;
			ones             <= '0;
			crc              <= CRC_INIT;
			fcs_lo           <= '0;
			idx              <= '0;
			pending          <= 1'b0;
			message_sent_out <= 1'b0;
		end else if (ce) begin
			mstate           <= next_mstate;
			sh               <= next_sh;
			bitn             <= next_bitn;
			ones             <= next_ones;
			crc              <= next_crc;
			fcs_lo           <= next_fcs_lo;
			idx              <= next_idx;
			pending          <= next_pending;
			message_sent_out <= next_sent;
		end
	end

	// writes outside the buffer window are dropped
	always_comb begin
		buf_hit = buf_wr_en && (buf_wr_addr >= BUF_BASE) && (buf_wr_addr <= BUF_LAST);
		buf_off = buf_wr_addr - BUF_BASE;
	end

	etol_msg_buffer #(
		.DEPTH (BUF_DEPTH),
		.AW    (7)
	) u_buf (
		.sys_clk (sys_clk),
		.ce      (ce),
		.wr_en   (buf_hit),
		.wr_addr (buf_off[6:0]),
		.wr_data (buf_wr_data),
		.rd_addr (idx),
		.rd_data (rd_data)
	);

endmodule

/* File: dv/etol_checker.sv */
module etol_checker
	import etol_pkg::*;
#(
	parameter logic [9:0] FAS_PATTERN = 10'h3D0
)(
	input wire logic       sys_clk,
	input wire logic       reset_n,
	input wire logic       tx_bit_out,
	input wire logic       ovh_frame_boundary_out,
	input wire logic       ovh_bit_strobe_out,
	input wire logic       ovh_insert_request_in,
	input wire logic       ovh_insert_value_in,
	input wire logic [1:0] n_bit_source_select,
	input wire logic       message_tx_enable,
	input wire logic       message_send_in,
	input wire logic       message_busy_out,
	input wire logic       message_sent_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	logic [3:0] k;
	logic [3:0] kreg;
	logic [3:0] next_kreg;
	// index of the strobe seen this cycle
	assign k = ovh_frame_boundary_out ? 4'h0 : kreg;
	always_comb begin
		next_kreg = ovh_bit_strobe_out ? k + 4'h1 : kreg;
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			kreg <= 4'h0;
		end else begin
			kreg <= next_kreg;
		end
	end
	AST_STROBE_RUN: assert property (ovh_frame_boundary_out |-> ovh_bit_strobe_out[*8]
		##1 (ovh_bit_strobe_out && !ovh_frame_boundary_out)[*4] ##1 !ovh_bit_strobe_out)
		else $error("strobe run length wrong");
	AST_FIRST_STROBE: assert property ($rose(ovh_bit_strobe_out) |-> ovh_frame_boundary_out)
		else $error("strobe run without boundary");
	AST_INSERT: assert property (ovh_bit_strobe_out ##1 ovh_insert_request_in
		|-> ##3 tx_bit_out == $past(ovh_insert_value_in, 3))
		else $error("inserted bit not sent");
	AST_ALIGN: assert property ((ovh_bit_strobe_out && k < 4'hA) ##1 !ovh_insert_request_in
		|-> ##3 tx_bit_out == FAS_PATTERN[4'h9 - $past(k, 4)])
		else $error("alignment bit wrong");
	AST_A_BIT: assert property ((ovh_bit_strobe_out && k == 4'hA) ##1 !ovh_insert_request_in
		|-> ##3 tx_bit_out == A_BIT_DEFAULT)
		else $error("default A bit wrong");
	AST_N_FIXED: assert property ((ovh_bit_strobe_out && k == 4'hB
		&& n_bit_source_select != NSRC_MSG) ##1 !ovh_insert_request_in |-> ##3 tx_bit_out)
		else $error("N bit not one");
	AST_SEND: assert property (message_send_in && message_tx_enable |=> message_busy_out)
		else $error("send not taken");
	AST_SENT: assert property (message_sent_out |-> $past(message_busy_out)
		##1 !message_sent_out)
		else $error("sent pulse wrong");
	cover property (ovh_frame_boundary_out);
	cover property (ovh_bit_strobe_out ##1 ovh_insert_request_in);
	cover property (message_sent_out);
endmodule
bind etol_tx_overhead_lapd etol_checker #(.FAS_PATTERN(FAS_PATTERN)) u_etol_checker (
	.sys_clk, .reset_n, .tx_bit_out, .ovh_frame_boundary_out, .ovh_bit_strobe_out,
	.ovh_insert_request_in, .ovh_insert_value_in, .n_bit_source_select,
	.message_tx_enable, .message_send_in, .message_busy_out, .message_sent_out
);

/* File: dv/etol_terminal.sv */
module etol_terminal (
	input  wire logic       sys_clk,
	input  wire logic       ovh_frame_boundary_out,
	input  wire logic       ovh_bit_strobe_out,
	input  wire logic [3:0] ins_idx,
	input  wire logic       ins_val,
	output logic            ovh_insert_request_in,
	output logic            ovh_insert_value_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt = 4'h0;
	logic [3:0] next_cnt;
	initial ovh_insert_request_in = 1'h0;
	initial ovh_insert_value_in = 1'h0;
	// acts only on sampled strobes, so request and bit hold until the next one
	always @(posedge sys_clk) begin
		if (ovh_bit_strobe_out) begin
			next_cnt = ovh_frame_boundary_out ? 4'h0 : cnt + 4'h1;
			cnt <= next_cnt;
			ovh_insert_request_in <= next_cnt == ins_idx;
			ovh_insert_value_in <= next_cnt == ins_idx ? ins_val : !ovh_insert_value_in;
		end
	end
endmodule

/* File: dv/etol_tx_overhead_lapd_tb.sv */
module etol_tx_overhead_lapd_tb
	import etol_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int         FB        = 20;
	localparam logic [9:0] ALIGN_PAT = 10'h1B3;
	localparam logic [7:0] CODES [4] = '{8'h38, 8'h34, 8'h32, 8'h3F};
	logic       sys_clk, reset_n, payload_bit_in, payload_bit_take, tx_bit_out, ins_val;
	logic       ovh_frame_boundary_out, ovh_bit_strobe_out, ovh_insert_request_in;
	logic       ovh_insert_value_in, message_tx_enable, message_size_select, buf_wr_en;
	logic       message_cr_select, message_send_in, message_busy_out, message_sent_out;
	logic       sync = 1'h0;
	logic       pay_d, pay_v;
	logic [1:0] n_bit_source_select;
	logic [3:0] stb_d, bnd_d;
	logic [3:0] ins_idx, kr;
	logic [7:0] buf_wr_addr, buf_wr_data, raw, dat;
	logic [7:0] ovh_q[$], byte_q[$], got[$];
	int         num_errors, num_checks, cycles, ones, bc, flags;
	etol_tx_overhead_lapd #(.FRAME_BITS(FB), .FAS_PATTERN(ALIGN_PAT)) u_etol_tx_overhead_lapd (
		.sys_clk, .reset_n, .ce(1'h1), .payload_bit_in, .payload_bit_take, .tx_bit_out,
		.ovh_frame_boundary_out, .ovh_bit_strobe_out, .ovh_insert_request_in,
		.ovh_insert_value_in, .n_bit_source_select, .message_tx_enable, .message_size_select,
		.message_cr_select, .message_send_in, .buf_wr_en, .buf_wr_addr, .buf_wr_data,
		.message_busy_out, .message_sent_out);
	etol_terminal u_etol_terminal (.sys_clk, .ovh_frame_boundary_out, .ovh_bit_strobe_out,
		.ins_idx, .ins_val, .ovh_insert_request_in, .ovh_insert_value_in);
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic nbit(input logic b);
		raw = {b, raw[7:1]};
		if (raw == 8'h7E) begin
			if (got.size() > 0) begin
				check("msg len", 8'(byte_q.size()), 8'(got.size()));
				foreach (got[i])
					if (byte_q.size() > 0) check("msg byte", byte_q.pop_front(), got[i]);
			end
			got = {};
			{bc, ones, sync} = {32'h0000_0000, 32'h0000_0000, 1'h1};
			flags++;
		end else if (ones == 5 && !b) begin
			ones = 0;
		end else begin
			ones = b ? ones + 1 : 0;
			dat = {b, dat[7:1]};
			bc = bc == 7 ? 0 : bc + 1;
			if (bc == 0 && sync) got.push_back(dat);
		end
	endtask
	initial begin
		sys_clk = 1'h0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(negedge sys_clk) payload_bit_in <= 1'($urandom);
	// results land four cycles after their strobe
	always @(posedge sys_clk) begin
		stb_d <= {stb_d[2:0], ovh_bit_strobe_out};
		bnd_d <= {bnd_d[2:0], ovh_frame_boundary_out};
		if (pay_d === 1'h1) check("payload bit", {7'h00, pay_v}, {7'h00, tx_bit_out});
		pay_d <= payload_bit_take && reset_n;
		pay_v <= payload_bit_in;
		cycles++;
		if (cycles == 90000) begin
			num_errors++;
			tally_and_finish();
		end
		if (stb_d[3] === 1'h1) begin
			kr = bnd_d[3] ? 4'h0 : kr + 4'h1;
			if (ovh_q.size() > 0) check("ovh bit", ovh_q.pop_front(), {7'h00, tx_bit_out});
			if (kr == 4'hB && n_bit_source_select == 2'h2) nbit(tx_bit_out);
		end
	end
	task automatic send_msg(input logic [7:0] code);
		logic [7:0]  m[$];
		logic [7:0]  b;
		logic [15:0] crc;
		@(negedge sys_clk);
		message_size_select = code == 8'h3F;
		message_cr_select = 1'($urandom);
		m = {message_cr_select ? 8'h3E : 8'h3C, 8'h01, 8'h03};
		for (int i = -1; i < 89; i++) begin
			@(negedge sys_clk);
			b = i == 0 ? code : 8'($urandom);
			{buf_wr_en, buf_wr_addr, buf_wr_data} = {1'h1, 8'h86 + 8'(i), b};
			if (i >= 0 && i < (message_size_select ? 82 : 76)) m.push_back(b);
		end
		crc = 16'hFFFF;
		foreach (m[i])
			for (int j = 0; j < 8; j++) crc = (crc >> 1) ^ (crc[0] ^ m[i][j] ? 16'h8408 : 16'h0000);
		m.push_back(~crc[15:8]);
		m.push_back(~crc[7:0]);
		byte_q = m;
		@(negedge sys_clk);
		{buf_wr_en, message_send_in} = 2'h1;
		@(negedge sys_clk);
		message_send_in = 1'h0;
		while (message_sent_out !== 1'h1) @(negedge sys_clk);
		repeat (2 * FB) @(negedge sys_clk);
		check("bytes left", 8'h00, 8'(byte_q.size()));
	endtask
	initial begin
		void'($urandom(25));
		{reset_n, message_tx_enable, message_size_select, message_cr_select,
			message_send_in, buf_wr_en, buf_wr_addr, buf_wr_data, n_bit_source_select} = '0;
		{ins_idx, ins_val} = 5'h1E;
		repeat (6) @(negedge sys_clk);
		reset_n = 1'h1;
		for (int k = 0; k < 13; k++) begin
			while (ovh_frame_boundary_out !== 1'h1) @(negedge sys_clk);
			repeat (16) @(negedge sys_clk);
			ins_idx = 4'(k);
			ins_val = k == 10 ? 1'h1 : 1'($urandom);
			for (int j = 0; j < 12; j++)
				ovh_q.push_back(8'(j == k ? ins_val : j < 10 ? ALIGN_PAT[9 - j] : j == 11));
		end
		repeat (2 * FB) @(negedge sys_clk);
		{n_bit_source_select, message_tx_enable} = 3'h5;
		while (flags < 3) @(negedge sys_clk);
		foreach (CODES[i]) send_msg(CODES[i]);
		tally_and_finish();
	end
endmodule
